// file: rtl/dhrm_cfg.svh
// Offsets, field positions, limits and timing counts of the drive map.
// Included by the filter, hour counter and register map files; definitions only.
`ifndef DHRM_CFG_SVH
`define DHRM_CFG_SVH

`define DHRM_OFS_FREQ_CMD      16'h0002
`define DHRM_OFS_STATE         16'h0003
`define DHRM_OFS_PV            16'h0005
`define DHRM_OFS_TRIP_CNT      16'h0011
`define DHRM_OFS_FREQ_MON      16'h1002
`define DHRM_OFS_CURR_MON      16'h1003
`define DHRM_OFS_ROT_DIR       16'h1004
`define DHRM_OFS_FB_HI         16'h1005
`define DHRM_OFS_FB_LO         16'h1006
`define DHRM_OFS_IN_TERM       16'h1007
`define DHRM_OFS_OUT_TERM      16'h1008
`define DHRM_OFS_SFREQ_HI      16'h1009
`define DHRM_OFS_SFREQ_LO      16'h100A
`define DHRM_OFS_VOLT_MON      16'h100C
`define DHRM_OFS_RUN_HI        16'h100E
`define DHRM_OFS_RUN_LO        16'h100F
`define DHRM_OFS_PON_HI        16'h1010
`define DHRM_OFS_PON_LO        16'h1011
`define DHRM_OFS_HEATSINK      16'h116A
`define DHRM_OFS_DC_BUS        16'h116C
`define DHRM_OFS_THERMAL       16'h116D

`define DHRM_MAX_FREQ          16'h0FA0
`define DHRM_MAX_PV            16'h03E8
`define DHRM_MAX_CURR          16'h07D0
`define DHRM_MAX_VOLT          16'h4E20
`define DHRM_MAX_TEMP          16'h07D0
`define DHRM_MAX_DCBUS         16'h270F
`define DHRM_MAX_THERM         16'h03E8
`define DHRM_MAX_STATE         16'h0009
`define DHRM_MAX_FB            32'h000F_41DC
`define DHRM_MAX_SFREQ         32'h003C_F960
`define DHRM_MAX_HOURS         32'h000F_423F

`define DHRM_FREQ_SRC_NET      8'h03
`define DHRM_FB_SRC_NET        8'h02

`define DHRM_EXC_NONE          8'h00
`define DHRM_EXC_RANGE         8'h21
`define DHRM_EXC_READ_ONLY     8'h22

`define DHRM_IN_TERM_MASK      16'h001F
`define DHRM_OUT_TERM_MASK     16'h073F

`define DHRM_CLK_MHZ           250
`define DHRM_FILT_TAU_MS       100
`define DHRM_FILT_CYCLES       (`DHRM_FILT_TAU_MS * `DHRM_CLK_MHZ * 1000)
`define DHRM_FILT_SHIFT        4
`define DHRM_SEC_PER_HOUR      3600
// 64-bit cast: an hour of cycles overflows 32-bit arithmetic
`define DHRM_HOUR_CYCLES       (64'(`DHRM_SEC_PER_HOUR) * `DHRM_CLK_MHZ * 1000000)

`endif

// file: rtl/dhrm_current_filter.sv
// First order low-pass for the output current monitor.
// Assumes the raw sample is valid every enabled clock.
`timescale 1ns/1ps
`include "dhrm_cfg.svh"

module dhrm_current_filter
    import dhrm_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = (`DHRM_FILT_CYCLES >> `DHRM_FILT_SHIFT)
) (
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic        clk_en,
    input  wire logic [15:0] raw_in,
    output logic      [15:0] filt_out
);

    // Tick period is tau/16, so alpha 1/16 per tick gives tau
    logic [31:0] tick_cnt_q;
    logic [23:0] acc_q;
    wire         tick = (tick_cnt_q >= TICK_CYCLES - 1);
    wire  [23:0] acc_next = acc_q - (acc_q >> `DHRM_FILT_SHIFT)
                            + {8'h00, raw_in};

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            tick_cnt_q <= 32'h0000_0000;
            acc_q      <= 24'h00_0000;
        end else if (clk_en) begin
            tick_cnt_q <= tick ? 32'h0000_0000 : tick_cnt_q + 32'h1;
            if (tick) begin
                acc_q <= acc_next;
            end
        end
    end

    assign filt_out = acc_q[`DHRM_FILT_SHIFT +: 16];

endmodule : dhrm_current_filter

// file: rtl/dhrm_hour_counter.sv
// Saturating hour counter driven by a count enable.
// Assumes count_en is a level sampled on sys_clk.
`timescale 1ns/1ps
`include "dhrm_cfg.svh"

module dhrm_hour_counter
    import dhrm_pkg::*;
#(
    parameter longint unsigned HOUR_CYCLES = `DHRM_HOUR_CYCLES
) (
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic        clk_en,
    input  wire logic        count_en,
    output logic      [31:0] hours
);

    logic [39:0] sub_q;
    logic [31:0] hours_q;
    wire         hour_done = (sub_q >= 40'(HOUR_CYCLES - 1));

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sub_q   <= 40'h00_0000_0000;
            hours_q <= 32'h0000_0000;
        end else if (clk_en && count_en) begin
            sub_q <= hour_done ? 40'h00_0000_0000 : sub_q + 40'h1;
            // Holds at the display limit rather than wrapping
            if (hour_done && hours_q < `DHRM_MAX_HOURS) begin
                hours_q <= hours_q + 32'h1;
            end
        end
    end

    assign hours = hours_q;

endmodule : dhrm_hour_counter

// file: rtl/dhrm_pkg.sv
// Types shared by the drive holding register map.
// Numeric constants live in dhrm_cfg.svh.
package dhrm_pkg;

    typedef enum logic [3:0] {
        DHRM_ST_INITIAL,
        DHRM_ST_RESERVED,
        DHRM_ST_STOP,
        DHRM_ST_RUN,
        DHRM_ST_COAST,
        DHRM_ST_JOG,
        DHRM_ST_DC_BRAKE,
        DHRM_ST_RETRY,
        DHRM_ST_TRIP,
        DHRM_ST_UNDERVOLT
    } dhrm_state_t;

    typedef enum logic [1:0] {
        DHRM_ACC_NONE,
        DHRM_ACC_RO,
        DHRM_ACC_RW
    } dhrm_access_t;

    typedef logic [15:0] dhrm_word_t;

endpackage : dhrm_pkg

// file: rtl/dhrm_regmap.sv
// Holding register bank of a motor drive, seen from the network side.
// Assumes a frame engine that gives one word request per strobe and
// returns the exception code; drive core supplies live samples.
//
// Functional notes
// R1: Network integers are engineering values times 10 or 100; held scaled.
// R2: Master scales written values into the listed range and reads back.
// R3: One bit stands for the register's resolution, possibly fractional.
// R4: Wide values use two consecutive offsets, high word then low word.
// R5: Frequency command 0..4000, used only when source select is 03.
// R6: Drive state register reports code 0 to 9, read only.
// R7: Process value 0..1000, PID feedback only when source select is 02.
// R8: Live output frequency reported 0..4000, read only.
// R9: Output current filtered with 100 ms constant, 0..2000.
// R10: Scaled PID feedback reported as word pair up to 999900.
// R11: Five input terminals in bits 0 to 4.
// R12: Output terminal bits 0..5 and 8..10 reported.
// R13: Scaled output frequency as word pair up to 3996000.
// R14: Output voltage reported 0..20000.
// R15: Run and power-on hour counters, word pairs up to 999999.
// R16: Heatsink temperature reported 0..2000.
// R17: Trip events counted 0 to 65535, read only.
// R18: DC bus voltage reported 0..9999.
// R19: Electronic thermal accumulation reported 0..1000.
// R20: Writes to read-only registers answer 22h and change nothing.
// R21: Writes outside the permitted range answer 21h.
// R22: Unlisted offsets read zero; writes to them answer 22h.
`timescale 1ns/1ps
`include "dhrm_cfg.svh"

module dhrm_regmap
    import dhrm_pkg::*;
#(
    parameter int unsigned     FILT_TICK   =
        (`DHRM_FILT_CYCLES >> `DHRM_FILT_SHIFT),
    parameter longint unsigned HOUR_CYCLES = `DHRM_HOUR_CYCLES
) (
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic        clk_en,
    // Word request from the frame engine
    input  wire logic        req_valid,
    input  wire logic        req_write,
    input  wire logic [15:0] req_addr,
    input  wire logic [15:0] req_wdata,
    output logic             rsp_valid,
    output logic      [15:0] rsp_rdata,
    output logic      [7:0]  rsp_exception,
    // Source selections held in the parameter store
    input  wire logic [7:0]  freq_source_select,
    input  wire logic [7:0]  feedback_source_select,
    input  wire logic [15:0] feedback_scale_factor,
    input  wire logic [15:0] freq_display_scale,
    input  wire logic [15:0] local_freq_ref,
    input  wire logic [15:0] local_process_value,
    // Live drive samples
    input  wire logic [3:0]  drive_state,
    input  wire logic [15:0] output_freq,
    input  wire logic [15:0] output_current_raw,
    input  wire logic [1:0]  rotation_dir,
    input  wire logic [4:0]  input_terminals,
    input  wire logic        run_output,
    input  wire logic        freq_arrival_const,
    input  wire logic        freq_arrival_over,
    input  wire logic        overload_output,
    input  wire logic        pid_deviation_output,
    input  wire logic        alarm_output,
    input  wire logic        dc_output,
    input  wire logic        feedback_compare_output,
    input  wire logic        network_loss_output,
    input  wire logic [15:0] output_voltage,
    input  wire logic [15:0] heatsink_temp,
    input  wire logic [15:0] dc_bus_volt,
    input  wire logic [15:0] thermal_accum,
    input  wire logic        trip_event,
    // Selected values handed to the drive core
    output logic      [15:0] freq_ref_out,
    output logic      [15:0] pid_feedback_out
);

    ////////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic logic [15:0] sat16(input logic [15:0] v,
                                          input logic [15:0] lim);
        sat16 = (v > lim) ? lim : v;
    endfunction : sat16

    function automatic logic [31:0] sat32(input logic [31:0] v,
                                          input logic [31:0] lim);
        sat32 = (v > lim) ? lim : v;
    endfunction : sat32

    ////////////////////////////////////////////////////////////////////////
    // Writable registers and counters

    logic [15:0] output_freq_command_q;
    logic [15:0] network_process_value_q;
    logic [15:0] trip_event_count_q;
    logic        trip_event_d1_q;
    logic        rsp_valid_q;
    logic [15:0] rsp_rdata_q;
    logic [7:0]  rsp_exception_q;
    logic [15:0] curr_filt;
    logic [31:0] run_hours;
    logic [31:0] power_on_hours;

    dhrm_current_filter #(
        .TICK_CYCLES (FILT_TICK)
    ) u_curr_filt (
        .sys_clk  (sys_clk),
        .rst_n    (rst_n),
        .clk_en   (clk_en),
        .raw_in   (output_current_raw),
        .filt_out (curr_filt)                                    // R9
    );

    wire drive_running = (drive_state == 4'(DHRM_ST_RUN)) ||
                         (drive_state == 4'(DHRM_ST_JOG));

    dhrm_hour_counter #(
        .HOUR_CYCLES (HOUR_CYCLES)
    ) u_run_hours (
        .sys_clk  (sys_clk),
        .rst_n    (rst_n),
        .clk_en   (clk_en),
        .count_en (drive_running),                               // R15
        .hours    (run_hours)
    );

    dhrm_hour_counter #(
        .HOUR_CYCLES (HOUR_CYCLES)
    ) u_pon_hours (
        .sys_clk  (sys_clk),
        .rst_n    (rst_n),
        .clk_en   (clk_en),
        .count_en (1'b1),                                        // R15
        .hours    (power_on_hours)
    );

    ////////////////////////////////////////////////////////////////////////
    // Derived monitor values

    // Scaled values are computed wide and clipped to the display range
    wire [31:0] fb_product    = 32'(pid_feedback_out) *
                                32'(feedback_scale_factor);
    wire [31:0] sfreq_product = 32'(output_freq) *
                                32'(freq_display_scale);
    wire [31:0] fb_mon    = sat32(fb_product, `DHRM_MAX_FB);        // R10
    wire [31:0] sfreq_mon = sat32(sfreq_product, `DHRM_MAX_SFREQ);  // R13
    wire [15:0] out_term  = {5'h00, network_loss_output,
                             feedback_compare_output, dc_output,
                             2'b00, alarm_output, pid_deviation_output,
                             overload_output, freq_arrival_over,
                             freq_arrival_const, run_output};       // R12
    wire [15:0] state_mon = (16'(drive_state) > `DHRM_MAX_STATE) ?
                            16'(DHRM_ST_INITIAL) : 16'(drive_state); // R6

    // R5
    assign freq_ref_out = (freq_source_select == `DHRM_FREQ_SRC_NET) ?
                          output_freq_command_q : local_freq_ref;
    // R7
    assign pid_feedback_out =
        (feedback_source_select == `DHRM_FB_SRC_NET) ?
        network_process_value_q : local_process_value;

    ////////////////////////////////////////////////////////////////////////
    // Address decode

    logic [15:0]  rd_word;
    dhrm_access_t acc;

    always_comb begin
        rd_word = 16'h0000;
        acc     = DHRM_ACC_RO;
        case (req_addr)
            `DHRM_OFS_FREQ_CMD: begin
                rd_word = output_freq_command_q;
                acc     = DHRM_ACC_RW;
            end
            `DHRM_OFS_STATE:    rd_word = state_mon;
            `DHRM_OFS_PV: begin
                rd_word = network_process_value_q;
                acc     = DHRM_ACC_RW;
            end
            `DHRM_OFS_TRIP_CNT: rd_word = trip_event_count_q;     // R17
            `DHRM_OFS_FREQ_MON:
                rd_word = sat16(output_freq, `DHRM_MAX_FREQ);     // R8
            `DHRM_OFS_CURR_MON:
                rd_word = sat16(curr_filt, `DHRM_MAX_CURR);       // R9
            `DHRM_OFS_ROT_DIR:  rd_word = {14'h0000, rotation_dir};
            `DHRM_OFS_FB_HI:    rd_word = fb_mon[31:16];          // R4
            `DHRM_OFS_FB_LO:    rd_word = fb_mon[15:0];           // R4
            `DHRM_OFS_IN_TERM:
                rd_word = {11'h000, input_terminals}
                          & `DHRM_IN_TERM_MASK;                   // R11
            `DHRM_OFS_OUT_TERM:
                rd_word = out_term & `DHRM_OUT_TERM_MASK;        // R12
            `DHRM_OFS_SFREQ_HI: rd_word = sfreq_mon[31:16];       // R4
            `DHRM_OFS_SFREQ_LO: rd_word = sfreq_mon[15:0];        // R4
            `DHRM_OFS_VOLT_MON:
                rd_word = sat16(output_voltage, `DHRM_MAX_VOLT);  // R14
            `DHRM_OFS_RUN_HI:   rd_word = run_hours[31:16];       // R15
            `DHRM_OFS_RUN_LO:   rd_word = run_hours[15:0];        // R15
            `DHRM_OFS_PON_HI:   rd_word = power_on_hours[31:16];  // R15
            `DHRM_OFS_PON_LO:   rd_word = power_on_hours[15:0];   // R15
            `DHRM_OFS_HEATSINK:
                rd_word = sat16(heatsink_temp, `DHRM_MAX_TEMP);   // R16
            `DHRM_OFS_DC_BUS:
                rd_word = sat16(dc_bus_volt, `DHRM_MAX_DCBUS);    // R18
            `DHRM_OFS_THERMAL:
                rd_word = sat16(thermal_accum, `DHRM_MAX_THERM);  // R19
            default: begin
                rd_word = 16'h0000;                               // R22
                acc     = DHRM_ACC_NONE;
            end
        endcase
    end

    wire        is_freq_cmd = (req_addr == `DHRM_OFS_FREQ_CMD);
    // Raw integers kept as received; the core divides by 10 itself
    wire [15:0] wr_limit    = is_freq_cmd ? `DHRM_MAX_FREQ
                                          : `DHRM_MAX_PV;         // R1
    wire        wr_ro       = (acc != DHRM_ACC_RW);               // R20
    wire        wr_range    = (req_wdata > wr_limit);             // R21
    wire        wr_ok       = req_valid && req_write && !wr_ro && !wr_range;
    wire [7:0]  exc_d       = !req_write ? `DHRM_EXC_NONE :
                              wr_ro      ? `DHRM_EXC_READ_ONLY :  // R22
                              wr_range   ? `DHRM_EXC_RANGE :
                                           `DHRM_EXC_NONE;
    wire        trip_rise   = trip_event && !trip_event_d1_q;
    wire        trip_inc    = trip_rise && (trip_event_count_q != 16'hFFFF);

    ////////////////////////////////////////////////////////////////////////
    // State

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            output_freq_command_q   <= 16'h0000;
            network_process_value_q <= 16'h0000;
        end else if (clk_en && wr_ok) begin
            if (is_freq_cmd) begin
                output_freq_command_q <= req_wdata;               // R5
            end else begin
                network_process_value_q <= req_wdata;             // R7
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            trip_event_count_q <= 16'h0000;
            trip_event_d1_q    <= 1'b0;
        end else if (clk_en) begin
            trip_event_d1_q <= trip_event;
            if (trip_inc) begin
                trip_event_count_q <= trip_event_count_q + 16'h1; // R17
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rsp_valid_q     <= 1'b0;
            rsp_rdata_q     <= 16'h0000;
            rsp_exception_q <= `DHRM_EXC_NONE;
        end else if (clk_en) begin
            rsp_valid_q <= req_valid;
            if (req_valid) begin
                rsp_rdata_q     <= req_write ? 16'h0000 : rd_word; // R3
                rsp_exception_q <= exc_d;                         // R21
            end
        end
    end

    assign rsp_valid     = rsp_valid_q;
    assign rsp_rdata     = rsp_rdata_q;
    assign rsp_exception = rsp_exception_q;

endmodule : dhrm_regmap

// file: tb/dhrm_master_model.sv
// Network master model: one word request at a time.
// Assumes a free running sys_clk; drives on the falling edge.
`timescale 1ns/1ps
module dhrm_master_model (
    input  wire logic        sys_clk,
    output logic             req_valid,
    output logic             req_write,
    output logic      [15:0] req_addr,
    output logic      [15:0] req_wdata,
    input  wire logic        rsp_valid,
    input  wire logic [15:0] rsp_rdata,
    input  wire logic [7:0]  rsp_exception
);
    logic miss;
    initial {req_valid, req_write, req_addr, req_wdata, miss} = '0;
    ////////////////////////////////////////////////////////////
    // Idle address and data show inverted values so stale data cannot pass
    task automatic xfer(input logic wr, input logic [15:0] a, d,
                        output logic [15:0] q, output logic [7:0] e);
        @(negedge sys_clk);
        req_valid = 1'b1;
        req_write = wr;
        req_addr  = a;
        req_wdata = d;
        @(negedge sys_clk);
        req_valid = 1'b0;
        req_addr  = ~a;
        req_wdata = ~d;
        // Answer is due exactly one cycle after the strobe
        miss = (rsp_valid !== 1'b1);
        q = rsp_rdata;
        e = rsp_exception;
    endtask : xfer
endmodule : dhrm_master_model

// file: tb/dhrm_regmap_chk.sv
// Assertions on the request port and selection outputs of the map.
// Assumes drive samples are steady around each request.
`timescale 1ns/1ps
module dhrm_regmap_chk (
    input wire logic        sys_clk,
    input wire logic        rst_n,
    input wire logic        clk_en,
    input wire logic        req_valid,
    input wire logic        req_write,
    input wire logic [15:0] req_addr,
    input wire logic [15:0] req_wdata,
    input wire logic        rsp_valid,
    input wire logic [15:0] rsp_rdata,
    input wire logic [7:0]  rsp_exception,
    input wire logic [7:0]  freq_source_select,
    input wire logic [7:0]  feedback_source_select,
    input wire logic [15:0] local_freq_ref,
    input wire logic [15:0] local_process_value,
    input wire logic [3:0]  drive_state,
    input wire logic [15:0] output_freq,
    input wire logic [15:0] freq_ref_out,
    input wire logic [15:0] pid_feedback_out
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    wire take = req_valid && clk_en;
    wire rw_a = req_addr == 16'h0002 || req_addr == 16'h0005;
    wire cmd  = req_write && req_addr == 16'h0002;
    wire pvw  = req_write && req_addr == 16'h0005;
    sequence s_req(logic c);
        take && c ##1 clk_en;
    endsequence
    sequence s_resp(logic [7:0] x);
        rsp_valid && rsp_exception == x;
    endsequence
    ////////////////////////////////////////////////////////////
    chk_ro_write_refused: assert property (
        s_req(req_write && !rw_a) |-> s_resp(8'h22))
        else $error("fixed write not refused");
    chk_cmd_range: assert property (
        s_req(cmd && req_wdata > 16'h0FA0) |-> s_resp(8'h21))
        else $error("cmd range not refused");
    chk_pv_range: assert property (
        s_req(pvw && req_wdata > 16'h03E8) |-> s_resp(8'h21))
        else $error("pv range not refused");
    chk_cmd_accept: assert property (
        s_req(cmd && req_wdata <= 16'h0FA0 && freq_source_select == 8'h03)
        |-> s_resp(8'h00) ##0 freq_ref_out == $past(req_wdata))
        else $error("cmd not applied");
    chk_pv_accept: assert property (
        s_req(pvw && req_wdata <= 16'h03E8
              && feedback_source_select == 8'h02)
        |-> s_resp(8'h00) ##0 pid_feedback_out == $past(req_wdata))
        else $error("pv not applied");
    chk_ref_local: assert property (
        freq_source_select != 8'h03 |-> freq_ref_out == local_freq_ref)
        else $error("freq ref not local");
    chk_fb_local: assert property (
        feedback_source_select != 8'h02
        |-> pid_feedback_out == local_process_value)
        else $error("feedback not local");
    chk_read_clean: assert property (
        s_req(!req_write) |-> s_resp(8'h00))
        else $error("read got exception");
    chk_state_code: assert property (
        s_req(!req_write && req_addr == 16'h0003 && drive_state <= 4'h9
              && $stable(drive_state))
        |-> rsp_rdata == {12'h000, $past(drive_state)})
        else $error("state code wrong");
    chk_freq_mon: assert property (
        s_req(!req_write && req_addr == 16'h1002 && $stable(output_freq))
        |-> rsp_rdata == ($past(output_freq) > 16'h0FA0 ? 16'h0FA0
                          : $past(output_freq)))
        else $error("freq monitor wrong");
    chk_resp_only: assert property (
        !take |=> !rsp_valid)
        else $error("answer without request");
endmodule : dhrm_regmap_chk

bind dhrm_regmap dhrm_regmap_chk dhrm_regmap_chk_inst (
    .sys_clk, .rst_n, .clk_en, .req_valid, .req_write, .req_addr,
    .req_wdata, .rsp_valid, .rsp_rdata, .rsp_exception,
    .freq_source_select, .feedback_source_select, .local_freq_ref,
    .local_process_value, .drive_state, .output_freq, .freq_ref_out,
    .pid_feedback_out
);

// file: tb/tb.sv
// Register map bench: access sequences with expected values.
// Assumes the master model and short filter and hour counts.
`timescale 1ns/1ps
module tb;
    logic        sys_clk, rst_n, clk_en, trip_event, req_valid, req_write;
    logic        rsp_valid;
    logic [15:0] req_addr, req_wdata, rsp_rdata, fscale, dscale, lref, lpv;
    logic [15:0] cur_raw, freq_ref_out, pid_feedback_out, q;
    logic [7:0]  rsp_exception, fsel, fbsel;
    logic [15:0] mon [5];
    logic [3:0]  drive_state;
    logic [1:0]  rotation_dir;
    logic [4:0]  input_terminals;
    logic [8:0]  ob;
    int          err_total = 0;
    int          n_compared = 0;
    localparam logic [15:0] MA [5] = '{16'h1002, 16'h100C, 16'h116A,
                                      16'h116C, 16'h116D};
    localparam logic [15:0] MX [5] = '{16'h0FA0, 16'h4E20, 16'h07D0,
                                      16'h270F, 16'h03E8};
    dhrm_regmap #(.FILT_TICK(4), .HOUR_CYCLES(10)) dhrm_regmap_inst (
        .sys_clk, .rst_n, .clk_en, .req_valid, .req_write, .req_addr,
        .req_wdata, .rsp_valid, .rsp_rdata, .rsp_exception,
        .freq_source_select(fsel), .feedback_source_select(fbsel),
        .feedback_scale_factor(fscale), .freq_display_scale(dscale),
        .local_freq_ref(lref), .local_process_value(lpv),
        .drive_state, .output_freq(mon[0]), .output_current_raw(cur_raw),
        .rotation_dir, .input_terminals, .run_output(ob[0]),
        .freq_arrival_const(ob[1]), .freq_arrival_over(ob[2]),
        .overload_output(ob[3]), .pid_deviation_output(ob[4]),
        .alarm_output(ob[5]), .dc_output(ob[6]),
        .feedback_compare_output(ob[7]), .network_loss_output(ob[8]),
        .output_voltage(mon[1]), .heatsink_temp(mon[2]),
        .dc_bus_volt(mon[3]), .thermal_accum(mon[4]), .trip_event,
        .freq_ref_out, .pid_feedback_out
    );
    dhrm_master_model dhrm_master_model_inst (
        .sys_clk, .req_valid, .req_write, .req_addr, .req_wdata,
        .rsp_valid, .rsp_rdata, .rsp_exception
    );
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    ////////////////////////////////////////////////////////////
    task automatic check16(input string n, input logic [15:0] e, g);
        n_compared++;
        if (g !== e) begin
            err_total++;
            $display("MISMATCH %s exp %h got %h", n, e, g);
        end
    endtask : check16
    task automatic check8(input string n, input logic [7:0] e, g);
        check16(n, 16'(e), 16'(g));
    endtask : check8
    task automatic check1(input string n, input logic e, g);
        check16(n, 16'(e), 16'(g));
    endtask : check1
    task automatic wr(input logic [15:0] a, d, input logic [7:0] x);
        logic [15:0] r;
        logic [7:0]  e;
        dhrm_master_model_inst.xfer(1'b1, a, d, r, e);
        check8($sformatf("write exc %h", a), x, e);
        check1("answer", 1'b0, dhrm_master_model_inst.miss);
    endtask : wr
    task automatic rdq(input logic [15:0] a, output logic [15:0] r);
        logic [7:0] e;
        dhrm_master_model_inst.xfer(1'b0, a, 16'h0000, r, e);
        check8($sformatf("read exc %h", a), 8'h00, e);
        check1("answer", 1'b0, dhrm_master_model_inst.miss);
    endtask : rdq
    task automatic rdc(input logic [15:0] a, x);
        logic [15:0] r;
        rdq(a, r);
        check16($sformatf("rdata %h", a), x, r);
    endtask : rdc
    task automatic rd32(input logic [15:0] a, input logic [31:0] w);
        rdc(a, w[31:16]);
        rdc(a + 16'h0001, w[15:0]);
    endtask : rd32
    task automatic print_verdict();
        if (err_total == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : print_verdict
    initial begin
        #200000;
        err_total++;
        print_verdict();
    end
    ////////////////////////////////////////////////////////////
    initial begin
        {clk_en, rst_n, trip_event, ob, cur_raw} = '0;
        clk_en = 1'b1;
        {fsel, fbsel, lref, lpv} = {8'h03, 8'h02, 16'h1234, 16'h0321};
        {fscale, dscale} = 32'h0000_0000;
        {drive_state, rotation_dir, input_terminals} = {4'h2, 2'h2, 5'h15};
        foreach (mon[i]) mon[i] = 16'h0000;
        repeat (2) @(posedge sys_clk);
        @(negedge sys_clk);
        rst_n = 1'b1;
        repeat (100) @(negedge sys_clk);
        rd32(16'h100E, 32'h0000_0000);
        rdq(16'h1011, q);
        check1("power on hours", 1'b1, q >= 16'h0009 && q <= 16'h000D);
        drive_state = 4'h3;
        repeat (200) @(negedge sys_clk);
        rdq(16'h100F, q);
        check1("run hours", 1'b1, q >= 16'h0013 && q <= 16'h0016);
        rdc(16'h0002, 16'h0000);
        rdc(16'h0011, 16'h0000);
        rdc(16'h0004, 16'h0000);
        wr(16'h0004, 16'h0001, 8'h22);
        wr(16'h1002, 16'h0001, 8'h22);
        wr(16'h0003, 16'h0001, 8'h22);
        wr(16'h0002, 16'h0FA0, 8'h00);
        wr(16'h0002, 16'h0FA1, 8'h21);
        rdc(16'h0002, 16'h0FA0);
        check16("freq ref", 16'h0FA0, freq_ref_out);
        wr(16'h0005, 16'h03E8, 8'h00);
        wr(16'h0005, 16'h03E9, 8'h21);
        rdc(16'h0005, 16'h03E8);
        check16("pid feedback", 16'h03E8, pid_feedback_out);
        fscale = 16'h0064;
        rd32(16'h1005, 32'h0001_86A0);
        fscale = 16'h07D0;
        rd32(16'h1005, 32'h000F_41DC);
        {fsel, fbsel} = 16'h0100;
        #1;
        check16("freq ref", 16'h1234, freq_ref_out);
        check16("pid feedback", 16'h0321, pid_feedback_out);
        for (int i = 0; i < 5; i++) begin
            mon[i] = MX[i] - 16'h0001;
            rdc(MA[i], MX[i] - 16'h0001);
            mon[i] = MX[i] + 16'h0001;
            rdc(MA[i], MX[i]);
        end
        {mon[0], dscale} = {16'h04D2, 16'h000A};
        rd32(16'h1009, 32'h0000_3034);
        {mon[0], dscale} = {16'h0FA0, 16'h03E8};
        rd32(16'h1009, 32'h003C_F960);
        for (int s = 0; s < 11; s++) begin
            drive_state = s[3:0];
            rdc(16'h0003, (s < 10) ? 16'(s) : 16'h0000);
        end
        rdc(16'h1004, 16'h0002);
        rdc(16'h1007, 16'h0015);
        for (int i = 0; i < 9; i++) begin
            ob = 9'h001 << i;
            rdc(16'h1008, 16'h0001 << ((i < 6) ? i : i + 2));
        end
        repeat (3) begin
            @(negedge sys_clk);
            trip_event = 1'b1;
            repeat (2) @(negedge sys_clk);
            trip_event = 1'b0;
        end
        rdc(16'h0011, 16'h0003);
        cur_raw = 16'h05DC;
        rdq(16'h1003, q);
        check1("filter lag", 1'b1, q < 16'h05DC);
        repeat (3000) @(negedge sys_clk);
        rdc(16'h1003, 16'h05DC);
        cur_raw = 16'h0BB8;
        repeat (3000) @(negedge sys_clk);
        rdc(16'h1003, 16'h07D0);
        print_verdict();
    end
endmodule : tb
